/* File: rtl/dbc_pkg.sv */
// Package for the debug control and breakpoint front end.
// Assumes a single 50 MHz core clock and an active-low asynchronous reset.
package dbc_pkg;

	// ==========================================================
	// Debug control register field positions
	// ==========================================================
	localparam int DBC_BIT_BYTE_ORDER   = 29;
	localparam int DBC_BIT_MISS_ONLY    = 26;
	localparam int DBC_BIT_OMIT_SPACE   = 25;
	localparam int DBC_BIT_ADDR_QUAL    = 24;
	localparam int DBC_BIT_ADDR_EN      = 23;
	localparam int DBC_BIT_ADDR_PRES    = 22;
	localparam int DBC_BIT_FAST_CHAN    = 18;
	localparam int DBC_BIT_DATA_BRK     = 17;
	localparam int DBC_BIT_INSTR_BRK    = 16;
	localparam int DBC_BIT_INV_VALUE    = 15;
	localparam int DBC_BIT_VALUE_STORE  = 14;
	localparam int DBC_BIT_VEC_RELOC    = 11;
	localparam int DBC_BIT_COMPLEX      = 10;
	localparam int DBC_BIT_SAMPLER_PRES = 9;
	localparam int DBC_BIT_RATE_LO      = 6;
	localparam int DBC_BIT_SAMPLER_EN   = 5;
	localparam int DBC_BIT_INT_GATE     = 4;
	localparam int DBC_BIT_NMI_GATE     = 3;
	localparam int DBC_BIT_NMI_WAIT     = 2;
	localparam int DBC_BIT_SRST_GATE    = 1;
	localparam int DBC_BIT_PROBE        = 0;

	// ==========================================================
	// Reset values and fixed presence values
	// ==========================================================
	localparam logic [2:0] DBC_RATE_RST       = 3'h7;
	localparam logic       DBC_VEC_RELOC_RST  = 1'h0;
	localparam logic       DBC_SAMPLER_EN_RST = 1'h0;
	localparam logic       DBC_INT_GATE_RST   = 1'h1;
	localparam logic       DBC_NMI_GATE_RST   = 1'h1;
	localparam logic       DBC_SRST_GATE_RST  = 1'h1;
	localparam logic       DBC_FAST_CHAN_VAL  = 1'h1;
	localparam logic       DBC_SAMPLER_PRES   = 1'h1;
	localparam logic       DBC_ABSENT_VAL     = 1'h0;

	// ==========================================================
	// Sampling timing and breakpoint sizes
	// ==========================================================
	localparam int DBC_RATE_BASE_LOG2 = 5;
	localparam int DBC_SAMPLE_CNT_W   = 12;
	localparam int DBC_MAX_IBRK       = 8;
	localparam int DBC_MAX_DBRK       = 4;
	localparam int DBC_SPACE_W        = 8;

	// Breakpoint set built into the core.
	typedef enum logic [2:0]
	{
		DBC_CFG_NONE   = 3'h0,
		DBC_CFG_2I1D   = 3'h1,
		DBC_CFG_4I2D   = 3'h2,
		DBC_CFG_6I2D   = 3'h3,
		DBC_CFG_6I2D_C = 3'h4,
		DBC_CFG_8I4D   = 3'h5,
		DBC_CFG_8I4D_C = 3'h6
	} dbc_cfg_t;

	// Instruction breakpoint channel settings.
	typedef struct packed
	{
		logic                   brk_en;
		logic                   trig_en;
		logic                   space_use;
		logic [31:0]            addr;
		logic [31:0]            addr_mask;
		logic [DBC_SPACE_W-1:0] space_id;
	} dbc_ibrk_t;

	// Data breakpoint channel settings.
	typedef struct packed
	{
		logic                   brk_en;
		logic                   trig_en;
		logic                   no_load;
		logic                   no_store;
		logic                   space_use;
		logic                   invert;
		logic [3:0]             lane_ign;
		logic [3:0]             lane_val_ign;
		logic [31:0]            addr;
		logic [31:0]            addr_mask;
		logic [DBC_SPACE_W-1:0] space_id;
		logic [31:0]            value;
	} dbc_dbrk_t;

	// One executed load or store transaction.
	typedef struct packed
	{
		logic                   valid;
		logic                   is_store;
		logic [31:0]            addr;
		logic [DBC_SPACE_W-1:0] space_id;
		logic [3:0]             lanes;
		logic [31:0]            data;
	} dbc_xact_t;

endpackage

/* File: rtl/dbc_ibrk_chan.sv */
// One instruction breakpoint channel comparator with a registered result.
// Assumes the PC is presented with a valid strobe for executed instructions.
`timescale 1ns/1ps
module dbc_ibrk_chan
	import dbc_pkg::*;
(
	// Clock and reset.
	input  wire logic                   sys_clk_in,
	input  wire logic                   nrst_in,
	// Channel settings and executed instruction.
	input  wire dbc_ibrk_t              cfg_in,
	input  wire logic                   pc_valid_in,
	input  wire logic [31:0]            pc_in,
	input  wire logic [DBC_SPACE_W-1:0] space_in,
	// Registered results for the same instruction.
	output logic                        brk_out,
	output logic                        trig_out
);

	// ==========================================================
	// Compare
	// ==========================================================
	logic hit;

	// Masked PC and optional space identifier compare.
	assign hit = pc_valid_in && (cfg_in.brk_en || cfg_in.trig_en) &&
		(((pc_in ^ cfg_in.addr) & ~cfg_in.addr_mask) == 32'h0) &&
		(!cfg_in.space_use || (space_in == cfg_in.space_id)); // RULE_21

	// Result registers.
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			brk_out  <= 1'h0;
			trig_out <= 1'h0;
		end
		else
		begin
			brk_out  <= hit && cfg_in.brk_en;
			trig_out <= hit && cfg_in.trig_en;
		end
	end

endmodule // dbc_ibrk_chan

/* File: rtl/dbc_dbrk_chan.sv */
// One data breakpoint channel comparator with a registered result.
// Assumes the transaction is presented once per executed load or store.
`timescale 1ns/1ps
module dbc_dbrk_chan
	import dbc_pkg::*;
(
	// Clock and reset.
	input  wire logic      sys_clk_in,
	input  wire logic      nrst_in,
	// Channel settings and transaction.
	input  wire dbc_dbrk_t cfg_in,
	input  wire logic      inv_ok_in,
	input  wire dbc_xact_t xact_in,
	// Registered results for the same transaction.
	output logic           brk_out,
	output logic           trig_out
);

	// ==========================================================
	// Compare
	// ==========================================================
	logic type_ok;
	logic addr_ok;
	logic no_val;
	logic val_eq;
	logic hit;

	// Transaction type, address, space and lane terms.
	assign type_ok = xact_in.is_store ? !cfg_in.no_store : !cfg_in.no_load;
	assign addr_ok = (((xact_in.addr ^ cfg_in.addr) & ~cfg_in.addr_mask)
		== 32'h0) &&
		(!cfg_in.space_use || (xact_in.space_id == cfg_in.space_id)) &&
		((xact_in.lanes & ~cfg_in.lane_ign) != 4'h0);
	assign no_val = ((cfg_in.lane_val_ign | cfg_in.lane_ign |
		~xact_in.lanes) == 4'hF);

	// Lane-wise value compare, optionally inverted.
	always_comb
	begin
		val_eq = 1'h1;
		for (int i = 0; i < 4; i++)
		begin
			if (xact_in.lanes[i] && !cfg_in.lane_val_ign[i] &&
				!cfg_in.lane_ign[i] &&
				(xact_in.data[i*8 +: 8] != cfg_in.value[i*8 +: 8]))
				val_eq = 1'h0;
		end
	end

	assign hit = xact_in.valid && (cfg_in.brk_en || cfg_in.trig_en) &&
		type_ok && addr_ok &&
		(no_val || (val_eq ^ (cfg_in.invert && inv_ok_in))); // RULE_22

	// Result registers.
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			brk_out  <= 1'h0;
			trig_out <= 1'h0;
		end
		else
		begin
			brk_out  <= hit && cfg_in.brk_en;
			trig_out <= hit && cfg_in.trig_en;
		end
	end

endmodule // dbc_dbrk_chan

/* File: rtl/dbc_top.sv */
// Debug control register, PC sample timer and breakpoint front end.
// Assumes the core supplies register access strobes, executed PCs and
// load/store transactions on the core clock; all inputs are synchronous.
//
// Overview of operation
// RULE_01: Byte order bit mirrors external strap.
// RULE_02: Hard and soft reset load field defaults.
// RULE_03: Miss-only sampling bit reads zero.
// RULE_04: Omit-space-id bit reads zero.
// RULE_05: Three address-sampling bits read zero.
// RULE_06: Fast channel presence bit reads one.
// RULE_07: Data and instruction breakpoint presence preset.
// RULE_08: Inverted match, value store presence preset.
// RULE_09: Relocated vector when trap zero, relocate set.
// RULE_10: Complex breakpoint presence bit preset.
// RULE_11: PC sampler presence bit reads one.
// RULE_12: One sample every 2^(5+rate) cycles.
// RULE_13: Sample counter runs only when enabled.
// RULE_14: Interrupt gate blocks interrupts outside debug.
// RULE_15: NMI gate blocks NMI outside debug.
// RULE_16: NMI waiting bit shows pending NMI.
// RULE_17: Soft reset gate driven out, unmasked.
// RULE_18: Bit 0 mirrors probe service flag.
// RULE_19: Unused bits read zero.
// RULE_20: Breakpoint set chosen at build time.
// RULE_21: Instruction breakpoints compare masked PC, space.
// RULE_22: Data breakpoints compare type, address, lanes, value.
// RULE_23: Data breakpoint reported on causing instruction.
// RULE_24: Writes to read-only fields are ignored.
`timescale 1ns/1ps
module dbc_top
	import dbc_pkg::*;
#(
	parameter dbc_cfg_t BRK_CFG          = DBC_CFG_8I4D_C,
	parameter logic     VALUE_STORE_PRES = 1'h1,
	parameter logic     INV_MATCH_PRES   = 1'h1
)
(
	// Clock and resets.
	input  wire logic                   sys_clk_in,
	input  wire logic                   nrst_in,
	input  wire logic                   soft_rst_in,
	// Register access from the debug segment.
	input  wire logic                   reg_wr_in,
	input  wire logic [31:0]            reg_wdata_in,
	output logic [31:0]                 reg_rdata_out,
	// Core state inputs.
	input  wire logic                   byte_order_flag_in,
	input  wire logic                   probe_service_flag_in,
	input  wire logic                   probe_trap_select_in,
	input  wire logic                   debug_mode_in,
	input  wire logic                   nmi_pending_in,
	input  wire logic                   int_req_in,
	input  wire logic                   nmi_req_in,
	input  wire logic [31:0]            relocated_vector_reg_in,
	input  wire logic [31:0]            default_vector_in,
	// Core controls.
	output logic                        int_take_out,
	output logic                        nmi_take_out,
	output logic [31:0]                 debug_vector_out,
	output logic                        soft_reset_gate_out,
	output logic                        pc_sample_out,
	// Breakpoint settings and executed work.
	input  wire dbc_ibrk_t [DBC_MAX_IBRK-1:0] ibrk_cfg_in,
	input  wire dbc_dbrk_t [DBC_MAX_DBRK-1:0] dbrk_cfg_in,
	input  wire logic                   pc_valid_in,
	input  wire logic [31:0]            pc_in,
	input  wire logic [DBC_SPACE_W-1:0] space_in,
	input  wire dbc_xact_t              xact_in,
	input  wire logic [DBC_MAX_IBRK-1:0] ibrk_flag_clr_in,
	input  wire logic [DBC_MAX_DBRK-1:0] dbrk_flag_clr_in,
	// Breakpoint results.
	output logic                        ibrk_exc_out,
	output logic                        dbrk_exc_out,
	output logic [DBC_MAX_IBRK-1:0]     ibrk_trig_out,
	output logic [DBC_MAX_DBRK-1:0]     dbrk_trig_out,
	output logic [DBC_MAX_IBRK-1:0]     ibrk_flag_out,
	output logic [DBC_MAX_DBRK-1:0]     dbrk_flag_out
);

	// ==========================================================
	// Build-time breakpoint set
	// ==========================================================
	localparam int NUM_IBRK =
		(BRK_CFG == DBC_CFG_NONE) ? 0 :
		(BRK_CFG == DBC_CFG_2I1D) ? 2 :
		(BRK_CFG == DBC_CFG_4I2D) ? 4 :
		((BRK_CFG == DBC_CFG_6I2D) ||
		 (BRK_CFG == DBC_CFG_6I2D_C)) ? 6 : 8; // RULE_20
	localparam int NUM_DBRK =
		(BRK_CFG == DBC_CFG_NONE) ? 0 :
		(BRK_CFG == DBC_CFG_2I1D) ? 1 :
		(NUM_IBRK == 8) ? 4 : 2; // RULE_20
	localparam logic COMPLEX_PRES = ((BRK_CFG == DBC_CFG_6I2D_C) ||
		(BRK_CFG == DBC_CFG_8I4D_C)) ? 1'h1 : 1'h0;
	localparam logic IBRK_PRES = (NUM_IBRK != 0) ? 1'h1 : 1'h0;
	localparam logic DBRK_PRES = (NUM_DBRK != 0) ? 1'h1 : 1'h0;

	// ==========================================================
	// Writable fields
	// ==========================================================
	logic       vec_reloc_r;
	logic [2:0] sample_rate_r;
	logic       sampler_enable_r;
	logic       interrupt_gate_r;
	logic       nonmaskable_gate_r;
	logic       soft_reset_gate_r;

	// Writable fields; soft reset reloads defaults like hard reset.
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			vec_reloc_r        <= DBC_VEC_RELOC_RST;
			sample_rate_r      <= DBC_RATE_RST;
			sampler_enable_r   <= DBC_SAMPLER_EN_RST;
			interrupt_gate_r   <= DBC_INT_GATE_RST;
			nonmaskable_gate_r <= DBC_NMI_GATE_RST;
			soft_reset_gate_r  <= DBC_SRST_GATE_RST;
		end
		else if (soft_rst_in) // RULE_02
		begin
			vec_reloc_r        <= DBC_VEC_RELOC_RST;
			sample_rate_r      <= DBC_RATE_RST;
			sampler_enable_r   <= DBC_SAMPLER_EN_RST;
			interrupt_gate_r   <= DBC_INT_GATE_RST;
			nonmaskable_gate_r <= DBC_NMI_GATE_RST;
			soft_reset_gate_r  <= DBC_SRST_GATE_RST;
		end
		else if (reg_wr_in)
		begin
			// Only writable bits are taken; all others are dropped.
			vec_reloc_r        <= reg_wdata_in[DBC_BIT_VEC_RELOC]; // RULE_24
			sample_rate_r      <= reg_wdata_in[DBC_BIT_RATE_LO +: 3];
			sampler_enable_r   <= reg_wdata_in[DBC_BIT_SAMPLER_EN];
			interrupt_gate_r   <= reg_wdata_in[DBC_BIT_INT_GATE];
			nonmaskable_gate_r <= reg_wdata_in[DBC_BIT_NMI_GATE];
			soft_reset_gate_r  <= reg_wdata_in[DBC_BIT_SRST_GATE];
		end
	end

	// ==========================================================
	// Read value
	// ==========================================================
	logic [31:0] rd_nxt;

	// Assemble the register image; unlisted bits stay zero.
	always_comb
	begin
		rd_nxt = 32'h0; // RULE_19
		rd_nxt[DBC_BIT_BYTE_ORDER]   = byte_order_flag_in; // RULE_01
		rd_nxt[DBC_BIT_MISS_ONLY]    = DBC_ABSENT_VAL; // RULE_03
		rd_nxt[DBC_BIT_OMIT_SPACE]   = DBC_ABSENT_VAL; // RULE_04
		rd_nxt[DBC_BIT_ADDR_QUAL]    = DBC_ABSENT_VAL; // RULE_05
		rd_nxt[DBC_BIT_ADDR_EN]      = DBC_ABSENT_VAL; // RULE_05
		rd_nxt[DBC_BIT_ADDR_PRES]    = DBC_ABSENT_VAL; // RULE_05
		rd_nxt[DBC_BIT_FAST_CHAN]    = DBC_FAST_CHAN_VAL; // RULE_06
		rd_nxt[DBC_BIT_DATA_BRK]     = DBRK_PRES; // RULE_07
		rd_nxt[DBC_BIT_INSTR_BRK]    = IBRK_PRES; // RULE_07
		rd_nxt[DBC_BIT_INV_VALUE]    = INV_MATCH_PRES; // RULE_08
		rd_nxt[DBC_BIT_VALUE_STORE]  = VALUE_STORE_PRES; // RULE_08
		rd_nxt[DBC_BIT_VEC_RELOC]    = vec_reloc_r;
		rd_nxt[DBC_BIT_COMPLEX]      = COMPLEX_PRES; // RULE_10
		rd_nxt[DBC_BIT_SAMPLER_PRES] = DBC_SAMPLER_PRES; // RULE_11
		rd_nxt[DBC_BIT_RATE_LO +: 3] = sample_rate_r;
		rd_nxt[DBC_BIT_SAMPLER_EN]   = sampler_enable_r;
		rd_nxt[DBC_BIT_INT_GATE]     = interrupt_gate_r;
		rd_nxt[DBC_BIT_NMI_GATE]     = nonmaskable_gate_r;
		rd_nxt[DBC_BIT_NMI_WAIT]     = nmi_pending_in; // RULE_16
		rd_nxt[DBC_BIT_SRST_GATE]    = soft_reset_gate_r;
		rd_nxt[DBC_BIT_PROBE]        = probe_service_flag_in; // RULE_18
	end

	// Registered read data, one cycle behind the state.
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			reg_rdata_out <= 32'h0;
		else
			reg_rdata_out <= rd_nxt;
	end

	// ==========================================================
	// Core controls
	// ==========================================================
	// Interrupt gating, vector choice and soft reset gate output.
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			int_take_out        <= 1'h0;
			nmi_take_out        <= 1'h0;
			debug_vector_out    <= 32'h0;
			soft_reset_gate_out <= DBC_SRST_GATE_RST;
		end
		else
		begin
			int_take_out <= int_req_in &&
				(debug_mode_in || interrupt_gate_r); // RULE_14
			nmi_take_out <= nmi_req_in &&
				(debug_mode_in || nonmaskable_gate_r); // RULE_15
			debug_vector_out <= (!probe_trap_select_in && vec_reloc_r) ?
				relocated_vector_reg_in : default_vector_in; // RULE_09
			soft_reset_gate_out <= soft_reset_gate_r; // RULE_17
		end
	end

	// ==========================================================
	// PC sample timer
	// ==========================================================
	logic [DBC_SAMPLE_CNT_W-1:0] sample_cnt_r;
	logic [DBC_SAMPLE_CNT_W-1:0] sample_last;

	// Terminal count is 2^(5+rate)-1.
	assign sample_last = DBC_SAMPLE_CNT_W'((13'h1 <<
		(DBC_RATE_BASE_LOG2 + int'(sample_rate_r))) - 13'h1); // RULE_12

	// Counter runs only while enabled and pulses once per interval.
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			sample_cnt_r  <= '0;
			pc_sample_out <= 1'h0;
		end
		else if (!sampler_enable_r || soft_rst_in) // RULE_13
		begin
			sample_cnt_r  <= '0;
			pc_sample_out <= 1'h0;
		end
		else if (sample_cnt_r >= sample_last) // RULE_12
		begin
			sample_cnt_r  <= '0;
			pc_sample_out <= 1'h1;
		end
		else
		begin
			sample_cnt_r  <= sample_cnt_r + 1'h1;
			pc_sample_out <= 1'h0;
		end
	end

	// ==========================================================
	// Breakpoint channels
	// ==========================================================
	logic [DBC_MAX_IBRK-1:0] ib_brk;
	logic [DBC_MAX_IBRK-1:0] ib_trig;
	logic [DBC_MAX_DBRK-1:0] db_brk;
	logic [DBC_MAX_DBRK-1:0] db_trig;
	logic                    in_normal;
	dbc_xact_t               xact_gated;

	// Breakpoints never match in debug mode.
	assign in_normal = !debug_mode_in;
	always_comb
	begin
		xact_gated       = xact_in;
		xact_gated.valid = xact_in.valid && in_normal;
	end

	// Build the configured channels; absent ones read as quiet.
	generate
		for (genvar i = 0; i < DBC_MAX_IBRK; i++)
		begin : g_ib
			if (i < NUM_IBRK)
			begin : g_on
				dbc_ibrk_chan u_chan
				(
					.sys_clk_in  (sys_clk_in),
					.nrst_in     (nrst_in),
					.cfg_in      (ibrk_cfg_in[i]),
					.pc_valid_in (pc_valid_in && in_normal),
					.pc_in       (pc_in),
					.space_in    (space_in),
					.brk_out     (ib_brk[i]),
					.trig_out    (ib_trig[i])
				);
			end
			else
			begin : g_off
				assign ib_brk[i]  = 1'h0;
				assign ib_trig[i] = 1'h0;
			end
		end
		for (genvar j = 0; j < DBC_MAX_DBRK; j++)
		begin : g_db
			if (j < NUM_DBRK)
			begin : g_on
				dbc_dbrk_chan u_chan
				(
					.sys_clk_in (sys_clk_in),
					.nrst_in    (nrst_in),
					.cfg_in     (dbrk_cfg_in[j]),
					.inv_ok_in  (INV_MATCH_PRES),
					.xact_in    (xact_gated),
					.brk_out    (db_brk[j]),
					.trig_out   (db_trig[j])
				);
			end
			else
			begin : g_off
				assign db_brk[j]  = 1'h0;
				assign db_trig[j] = 1'h0;
			end
		end
	endgenerate

	// Exception and trigger outputs, two cycles after the instruction.
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ibrk_exc_out  <= 1'h0;
			dbrk_exc_out  <= 1'h0;
			ibrk_trig_out <= '0;
			dbrk_trig_out <= '0;
		end
		else
		begin
			ibrk_exc_out  <= |ib_brk; // RULE_21
			dbrk_exc_out  <= |db_brk; // RULE_23
			ibrk_trig_out <= ib_trig;
			dbrk_trig_out <= db_trig; // RULE_23
		end
	end

	// Sticky match flags; a new match wins over a clear.
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ibrk_flag_out <= '0;
			dbrk_flag_out <= '0;
		end
		else
		begin
			ibrk_flag_out <= (ibrk_flag_out & ~ibrk_flag_clr_in) |
				ib_brk | ib_trig; // RULE_21
			dbrk_flag_out <= (dbrk_flag_out & ~dbrk_flag_clr_in) |
				db_brk | db_trig; // RULE_22
		end
	end

endmodule // dbc_top

/* File: sim/dbc_probe_model.sv */
// Stand-in for the system and probe around the block.
// Assumes the bench drives the raw soft reset and probe levels.
`timescale 1ns/1ps
module dbc_probe_model
(
	// System side.
	input  wire logic gate_in,
	input  wire logic req_in,
	input  wire logic probe_in,
	// Towards the block.
	output logic      soft_rst_out,
	output logic      flag_out
);
	// The system masks soft reset with the gate pin.
	assign soft_rst_out = req_in & gate_in;
	// The probe enable level reaches the block unchanged.
	assign flag_out = probe_in;
endmodule // dbc_probe_model

/* File: sim/dbc_top_checker.sv */
// Port checks on the debug control block.
// Assumes a bind into the block's top module.
`timescale 1ns/1ps
module dbc_top_checker
	import dbc_pkg::*;
(
	// Clock, resets and register access.
	input wire logic        sys_clk_in,
	input wire logic        nrst_in,
	input wire logic        soft_rst_in,
	input wire logic        reg_wr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic [31:0] reg_rdata_out,
	// Core state and controls.
	input wire logic        byte_order_flag_in,
	input wire logic        probe_service_flag_in,
	input wire logic        nmi_pending_in,
	input wire logic        debug_mode_in,
	input wire logic        nmi_req_in,
	input wire logic        nmi_take_out,
	input wire logic        soft_reset_gate_out,
	// Executed work and results.
	input wire logic        pc_valid_in,
	input wire dbc_xact_t   xact_in,
	input wire logic        ibrk_exc_out,
	input wire logic        dbrk_exc_out
);
	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!nrst_in);

	a_unused_zero: assert property (
		(reg_rdata_out & 32'h5FF8_3000) == 32'h0)
		else $error("Unused bits not zero.");
	a_mirror_in: assert property ($past(nrst_in) |->
		{reg_rdata_out[29], reg_rdata_out[2], reg_rdata_out[0]} ==
		$past({byte_order_flag_in, nmi_pending_in, probe_service_flag_in}))
		else $error("Mirror bits wrong.");
	a_ro_stable: assert property ($past(nrst_in, 2) && $past(nrst_in) |->
		$stable(reg_rdata_out & 32'h0007_C600))
		else $error("Preset bits changed.");
	a_write_fields: assert property (reg_wr_in && !soft_rst_in |->
		##2 (reg_rdata_out & 32'h9FA) == ($past(reg_wdata_in, 2) & 32'h9FA))
		else $error("Field not shown.");
	a_gate_pin: assert property (reg_wr_in && !soft_rst_in |->
		##2 soft_reset_gate_out == $past(reg_wdata_in[1], 2))
		else $error("Gate pin wrong.");
	a_soft_defaults: assert property (soft_rst_in |-> ##2
		(reg_rdata_out & 32'h9FA) == 32'h1DA)
		else $error("Soft reset values wrong.");
	a_nmi_debug: assert property ($past(nrst_in) &&
		$past(nmi_req_in && debug_mode_in) |-> nmi_take_out)
		else $error("NMI blocked in debug mode.");
	a_ibrk_cause: assert property (ibrk_exc_out |->
		$past(pc_valid_in, 2))
		else $error("Break without instruction.");
	a_dbrk_cause: assert property (dbrk_exc_out |->
		$past(xact_in.valid, 2))
		else $error("Break without transaction.");

	// Main scenarios seen.
	c_soft: cover property (soft_rst_in);
	c_ibrk: cover property (ibrk_exc_out);
	c_dbrk: cover property (dbrk_exc_out);
endmodule // dbc_top_checker

bind dbc_top dbc_top_checker dbc_top_checker_inst (.sys_clk_in, .nrst_in,
	.soft_rst_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out,
	.byte_order_flag_in, .probe_service_flag_in, .nmi_pending_in,
	.debug_mode_in, .nmi_req_in, .nmi_take_out, .soft_reset_gate_out,
	.pc_valid_in, .xact_in, .ibrk_exc_out, .dbrk_exc_out);

/* File: sim/dbc_top_tb.sv */
// Self-checking bench for the debug control block.
// Assumes the default build and the probe model.
`timescale 1ns/1ps
module dbc_top_tb
	import dbc_pkg::*;
;
	// Signals named after the ports they meet.
	logic sys_clk_in, nrst_in, soft_rst_in, reg_wr_in, srst_req, probe_lvl;
	logic byte_order_flag_in, probe_service_flag_in, probe_trap_select_in;
	logic debug_mode_in, nmi_pending_in, int_req_in, nmi_req_in;
	logic int_take_out, nmi_take_out, soft_reset_gate_out, pc_sample_out;
	logic pc_valid_in, ibrk_exc_out, dbrk_exc_out;
	logic [31:0] reg_wdata_in, reg_rdata_out, pc_in, d;
	logic [31:0] relocated_vector_reg_in, default_vector_in, debug_vector_out;
	logic [DBC_SPACE_W-1:0] space_in;
	dbc_ibrk_t [DBC_MAX_IBRK-1:0] ibrk_cfg_in;
	dbc_dbrk_t [DBC_MAX_DBRK-1:0] dbrk_cfg_in;
	dbc_xact_t xact_in;
	logic [DBC_MAX_IBRK-1:0] ibrk_flag_clr_in, ibrk_trig_out, ibrk_flag_out;
	logic [DBC_MAX_DBRK-1:0] dbrk_flag_clr_in, dbrk_trig_out, dbrk_flag_out;
	int fails = 0, checked = 0, seed = 31427, fld, r, c, k, ci, cd, ei, ed;

	dbc_top dbc_top_inst (.sys_clk_in, .nrst_in, .soft_rst_in, .reg_wr_in,
		.reg_wdata_in, .reg_rdata_out, .byte_order_flag_in,
		.probe_service_flag_in, .probe_trap_select_in, .debug_mode_in,
		.nmi_pending_in, .int_req_in, .nmi_req_in, .relocated_vector_reg_in,
		.default_vector_in, .int_take_out, .nmi_take_out, .debug_vector_out,
		.soft_reset_gate_out, .pc_sample_out, .ibrk_cfg_in, .dbrk_cfg_in,
		.pc_valid_in, .pc_in, .space_in, .xact_in, .ibrk_flag_clr_in,
		.dbrk_flag_clr_in, .ibrk_exc_out, .dbrk_exc_out, .ibrk_trig_out,
		.dbrk_trig_out, .ibrk_flag_out, .dbrk_flag_out);
	dbc_probe_model dbc_probe_model_inst (.gate_in(soft_reset_gate_out),
		.req_in(srst_req), .probe_in(probe_lvl),
		.soft_rst_out(soft_rst_in), .flag_out(probe_service_flag_in));

	// ==========================================================
	// Model and tasks
	// ==========================================================
	// Expected image of the default build.
	function automatic logic [31:0] img();
		return 32'h0007_C600 | fld | {2'h0, byte_order_flag_in, 29'h0}
			| {29'h0, nmi_pending_in, 1'h0, probe_service_flag_in};
	endfunction

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		checked++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tally_and_finish();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Unused bits written as zero; soft reset drops it.
	task automatic wr(input logic [31:0] v);
		reg_wdata_in = v & 32'h2007_CFFF;
		reg_wr_in = 1'h1;
		step(1);
		reg_wr_in = 1'h0;
		if (soft_rst_in !== 1'h1)
			fld = reg_wdata_in & 32'h9FA;
	endtask

	// Counts cycles to the next sample pulse, bounded.
	task automatic waitp(output int n);
		n = 0;
		while (pc_sample_out !== 1'h1)
		begin
			step(1);
			n++;
			if (n > 9000)
			begin
				fails++;
				tally_and_finish();
			end
		end
		step(1);
	endtask

	// ==========================================================
	// Clock and main sequence
	// ==========================================================
	initial
	begin
		sys_clk_in = 1'h0;
		forever #10 sys_clk_in = ~sys_clk_in;
	end

	initial
	begin
		{nrst_in, reg_wr_in, srst_req, probe_lvl, byte_order_flag_in} = '0;
		{probe_trap_select_in, debug_mode_in, nmi_pending_in} = '0;
		{int_req_in, nmi_req_in, pc_valid_in, pc_in, space_in} = '0;
		{reg_wdata_in, relocated_vector_reg_in, default_vector_in} = '0;
		{ibrk_flag_clr_in, dbrk_flag_clr_in, xact_in} = '0;
		{ibrk_cfg_in, dbrk_cfg_in} = '0;
		fld = 32'h1DA;
		repeat (12) @(posedge sys_clk_in);
		#1 nrst_in = 1'h1;
		step(2);
		chk("image", img(), reg_rdata_out);
		for (k = 0; k < 16; k++)
		begin
			d = $random(seed);
			{byte_order_flag_in, probe_lvl, nmi_pending_in} = d[31:29];
			{int_req_in, nmi_req_in} = d[15:14];
			{probe_trap_select_in, debug_mode_in} = d[13:12];
			relocated_vector_reg_in = $random(seed);
			default_vector_in = ~relocated_vector_reg_in;
			wr(d);
			step(1);
			chk("image", img(), reg_rdata_out);
			chk("gate", fld[1], soft_reset_gate_out);
			chk("int", int_req_in & (debug_mode_in | fld[4]), int_take_out);
			chk("nmi", nmi_req_in & (debug_mode_in | fld[3]), nmi_take_out);
			chk("vector", (!probe_trap_select_in && fld[11]) ?
				relocated_vector_reg_in : default_vector_in, debug_vector_out);
		end
		$display("register test done");
		wr(32'h0);
		step(2);
		srst_req = 1'h1;
		step(2);
		chk("masked", img(), reg_rdata_out);
		srst_req = 1'h0;
		wr(32'h2);
		step(2);
		srst_req = 1'h1;
		step(1);
		srst_req = 1'h0;
		fld = 32'h1DA;
		step(2);
		chk("soft reset", img(), reg_rdata_out);
		$display("soft reset test done");
		for (r = 0; r < 8; r++)
		begin
			wr({r[2:0], 6'h3A});
			waitp(c);
			waitp(c);
			chk("interval", 32'h20 << r, c + 1);
		end
		wr(32'h1A);
		step(2);
		c = 0;
		repeat (200)
		begin
			step(1);
			c += (pc_sample_out !== 1'h0);
		end
		chk("idle", 0, c);
		$display("sampler test done");
		ibrk_cfg_in[0] = '{1'h1, 1'h1, 1'h0, 32'h4000, 32'hF, 8'h0};
		dbrk_cfg_in[0] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 4'h0, 4'h0,
			32'h8000, 32'h0, 8'h0, 32'hCAFE_F00D};
		for (k = 0; k < 16; k++)
		begin
			d = $random(seed);
			debug_mode_in = &d[31:30];
			pc_in = 32'h4000 ^ (d & 32'h1F);
			xact_in = '{1'h1, d[9], 32'h8000, 8'h0, 4'hF,
				32'hCAFE_F00D ^ {31'h0, d[10] & d[11]}};
			dbrk_cfg_in[0].invert = d[12];
			pc_valid_in = 1'h1;
			step(1);
			pc_valid_in = 1'h0;
			xact_in.valid = 1'h0;
			ei = !debug_mode_in && !d[4];
			ed = !debug_mode_in && d[9] && ((d[10] && d[11]) == d[12]);
			{ci, cd} = '0;
			repeat (4)
			begin
				step(1);
				ci += (ibrk_exc_out === 1'h1) + (ibrk_trig_out === 8'h1);
				cd += (dbrk_exc_out === 1'h1) + (dbrk_trig_out !== 4'h0);
			end
			chk("ibrk", 2 * ei, ci);
			chk("iflag", ei, ibrk_flag_out[0]);
			chk("dbrk", ed, cd);
			chk("dflag", ed, dbrk_flag_out[0]);
			{ibrk_flag_clr_in, dbrk_flag_clr_in} = '1;
			step(1);
			{ibrk_flag_clr_in, dbrk_flag_clr_in} = '0;
			step(1);
		end
		$display("breakpoint test done");
		tally_and_finish();
	end
endmodule // dbc_top_tb
